// ### verilog/lsi_pkg.sv
// Constants, types and field layout of the LED status indicator
//Function
//- Mode 6 lit on 10/100 link, activity darkens
//- Mode 8 steadily lit on full-duplex link
//- Mode 8 half-duplex collisions flash lamp lit
//- Mode 9 dark, collisions flash lamp lit
//- Mode 10 activity flashes lit; optionally transmit-only
//- Mode 12 lit while negotiation fault present
//- Mode 14 dark, 15 lit; reserved modes dark
//- Per-pin combine adds secondary flashing to primary
//- Per-pin bit picks blink or pulse stretch
//- Blink runs at fifty percent duty
//- Blink: single event half period, continuous oscillates
//- Stretch: single event lasts one full period
//- Stretch continuous: ends one full period after last event
//- Stretch rest lasts at least half period
//- Rate selects 2.5, 5, 10, 20 Hz
//- Rate selects 50, 100, 200, 400 ms
//- Pulsing modulates lit lamps 5 kHz, 20%
//- Enhanced modes only when legacy bit clear
//- Power-down forces all lamps dark
`default_nettype none
package lsi_pkg;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_NS          = 8;
    localparam int TICK_NS         = 10_000;
    localparam int TICK_CYCLES     = (TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam int BLINK_HZ_MAX    = 20;
    localparam int PWM_HZ          = 5_000;
    localparam int PWM_DUTY_PCT    = 20;
    localparam logic [15:0] HALF_BLINK_TICKS =
        16'(1_000_000_000 / (2 * BLINK_HZ_MAX) / TICK_NS);
    localparam logic [7:0] PWM_PERIOD_TICKS =
        8'(1_000_000_000 / PWM_HZ / TICK_NS);
    localparam logic [7:0] PWM_ON_TICKS =
        8'(1_000_000_000 / PWM_HZ / TICK_NS * PWM_DUTY_PCT / 100);

    // ----------------------------------------------------------------
    // Register map and fields
    // ----------------------------------------------------------------
    localparam logic [7:0]  ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  ADDR_MODE   = 8'h04;
    localparam logic [7:0]  ADDR_BEHAV  = 8'h08;
    localparam logic [7:0]  ADDR_STATUS = 8'h0C;
    localparam int          CTRL_LEGACY = 0;
    localparam int          CTRL_PDOWN  = 1;
    localparam int          CTRL_W      = 2;
    localparam int          MODE_W      = 4;
    localparam int          BEH_COMB    = 0;
    localparam int          BEH_STR     = 2;
    localparam int          BEH_RATE    = 4;
    localparam int          RATE_W      = 2;
    localparam int          BEH_PULSE   = 8;
    localparam int          BEH_TXACT   = 9;
    localparam int          BEH_LINKACT = 15;
    localparam int          BEH_W       = 16;
    localparam int          NPIN        = 2;
    localparam logic [1:0]  CTRL_RST    = 2'h0;
    localparam logic [7:0]  MODE_RST    = 8'h6A;
    localparam logic [15:0] BEH_RST     = 16'h0000;
    localparam logic        LAMP_DARK   = 1'b1;

    localparam logic [1:0]  SPD_10      = 2'h0;
    localparam logic [1:0]  SPD_100     = 2'h1;
    localparam logic [1:0]  SPD_1000    = 2'h2;

    typedef enum logic [3:0] {
        M_LOW_SPEED_LINK_ACTIVITY = 4'h6,
        M_DUPLEX_COLLISION        = 4'h8,
        M_COLLISION               = 4'h9,
        M_ACTIVITY                = 4'hA,
        M_NEG_FAULT               = 4'hC,
        M_FORCE_OFF               = 4'hE,
        M_FORCE_ON                = 4'hF
    } lsi_mode_t;

    typedef enum logic [2:0] {
        SH_IDLE = 3'b001,
        SH_ON   = 3'b010,
        SH_REST = 3'b100
    } lsi_shape_t;
endpackage : lsi_pkg
`default_nettype wire

// ### verilog/lsi_shaper.sv
// Blink / pulse-stretch shaper for one lamp
`timescale 1ns/1ps
`default_nettype none
module lsi_shaper
    import lsi_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              tick,
    input  wire logic              event_in,
    input  wire logic              stretch_en,
    input  wire logic [RATE_W-1:0] rate,
    output var  logic              shaped
);
    lsi_shape_t  state;
    logic [15:0] cnt;
    logic [15:0] half;
    logic [15:0] full;
    logic        pending;
    logic        half_end;
    logic        full_end;
    logic        take;

    assign half     = HALF_BLINK_TICKS << rate;
    assign full     = half << 1;
    assign half_end = tick && (cnt >= half - 16'h0001);
    assign full_end = tick && (cnt >= full - 16'h0001);
    assign take     = (state == SH_IDLE) && (stretch_en || half_end);
    assign shaped   = (state == SH_ON);

    // Set beats clear; stretch only remembers events seen while resting
    always_ff @(posedge clk) begin
        if (rst) begin
            pending <= 1'b0;
        end else begin
            pending <= (event_in && (!stretch_en || state == SH_REST))
                     || (pending && !take);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= SH_IDLE;
            cnt   <= 16'h0000;
        end else begin
            case (state)
                SH_IDLE: begin
                    if (stretch_en) begin
                        if (event_in || pending) begin
                            state <= SH_ON;
                            cnt   <= 16'h0000;
                        end
                    end else begin
                        cnt <= half_end ? 16'h0000 : cnt + 16'(tick);
                        if (half_end && pending) begin
                            state <= SH_ON;
                        end
                    end
                end
                SH_ON: begin
                    if (!stretch_en) begin
                        cnt <= half_end ? 16'h0000 : cnt + 16'(tick);
                        if (half_end) begin
                            state <= SH_IDLE;
                        end
                    end else if (event_in) begin
                        cnt <= 16'h0000;
                    end else if (full_end) begin
                        state <= SH_REST;
                        cnt   <= 16'h0000;
                    end else begin
                        cnt <= cnt + 16'(tick);
                    end
                end
                SH_REST: begin
                    if (half_end) begin
                        state <= SH_IDLE;
                        cnt   <= 16'h0000;
                    end else begin
                        cnt <= cnt + 16'(tick);
                    end
                end
                default: begin
                    state <= SH_IDLE;
                    cnt   <= 16'h0000;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_stretch_lit;
        stretch_en && state == SH_ON && !event_in;
    endsequence

    a_blink_half_on: assert property (
        !stretch_en && state == SH_ON && half_end |=> state == SH_IDLE)
        else $error("blink on-phase did not end at half period");
    a_stretch_holds: assert property (
        stretch_en && state == SH_ON && event_in |=> state == SH_ON
        && cnt == 16'h0000)
        else $error("stretch not extended by event");
    a_stretch_full: assert property (
        s_stretch_lit ##0 !full_end |=> state == SH_ON)
        else $error("stretch ended before full period");
    a_stretch_rest: assert property (
        s_stretch_lit ##0 full_end |=> state == SH_REST
        ##0 cnt == 16'h0000)
        else $error("stretch did not enter rest");
    a_rest_minimum: assert property (
        state == SH_REST && !half_end |=> state == SH_REST)
        else $error("rest left early");
endmodule : lsi_shaper
`default_nettype wire

// ### verilog/lsi_led_status.sv
// Enhanced-mode status lamp driver with AHB-Lite register access
`timescale 1ns/1ps
`default_nettype none
module lsi_led_status
    import lsi_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES
)
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic        hreadyout,
    output var  logic        hresp,
    output var  logic [31:0] hrdata,
    input  wire logic        link_up,
    input  wire logic [1:0]  link_speed,
    input  wire logic        full_duplex,
    input  wire logic        collision,
    input  wire logic        rx_activity,
    input  wire logic        tx_activity,
    input  wire logic        neg_fault,
    input  wire logic        lamp_mode_strap,
    output var  logic        status_lamp_a_n,
    output var  logic        status_lamp_b_n
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [CTRL_W-1:0]      ctrl;
    logic [NPIN*MODE_W-1:0] mode_sel;
    logic [BEH_W-1:0]       behav;
    logic                   wr_pend;
    logic                   rd_pend;
    logic [7:0]             acc_addr;
    logic                   bus_take;
    logic [31:0]            rd_mux;
    logic [15:0]            div_cnt;
    logic                   tick;
    logic [7:0]             pwm_cnt;
    logic                   pwm_on;
    logic                   strap_q;
    logic                   strap_done;
    logic [NPIN-1:0]        lamp_n;
    logic                   legacy;
    logic                   power_down;
    logic                   any_act;
    logic                   link10;
    logic                   link100;
    logic                   link1000;

    assign legacy     = ctrl[CTRL_LEGACY];
    assign power_down = ctrl[CTRL_PDOWN];
    assign any_act    = rx_activity || tx_activity;
    assign link10     = link_up && link_speed == SPD_10;
    assign link100    = link_up && link_speed == SPD_100;
    assign link1000   = link_up && link_speed == SPD_1000;

    // ----------------------------------------------------------------
    // AHB-Lite slave
    // ----------------------------------------------------------------
    // Reads wait one cycle so a read right after a write sees new data
    // Writes never stall and the response is always OKAY
    assign bus_take  = hsel && hready && htrans[1];
    assign hreadyout = !rd_pend;
    assign hresp     = 1'b0;

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_pend  <= 1'b0;
            rd_pend  <= 1'b0;
            acc_addr <= 8'h00;
        end else begin
            wr_pend <= bus_take && hwrite;
            rd_pend <= bus_take && !hwrite;
            if (bus_take) begin
                acc_addr <= haddr[7:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl     <= CTRL_RST;
            mode_sel <= MODE_RST;
            behav    <= BEH_RST;
        end else if (wr_pend) begin
            case (acc_addr)
                ADDR_CTRL:  ctrl     <= hwdata[CTRL_W-1:0];
                ADDR_MODE:  mode_sel <= hwdata[NPIN*MODE_W-1:0];
                ADDR_BEHAV: behav    <= hwdata[BEH_W-1:0];
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        case (acc_addr)
            ADDR_CTRL:   rd_mux = {30'h0, ctrl};
            ADDR_MODE:   rd_mux = {24'h0, mode_sel};
            ADDR_BEHAV:  rd_mux = {16'h0, behav};
            ADDR_STATUS: rd_mux = {21'h0, strap_q, ~lamp_n,
                                   neg_fault, tx_activity, rx_activity,
                                   collision, full_duplex, link_speed,
                                   link_up};
            default:     rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_pend) begin
            hrdata <= rd_mux;
        end
    end

    // ----------------------------------------------------------------
    // Strap capture
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            strap_q    <= 1'b0;
            strap_done <= 1'b0;
        end else if (!strap_done) begin
            strap_q    <= lamp_mode_strap;
            strap_done <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Timebases
    // ----------------------------------------------------------------
    assign tick   = (div_cnt == 16'(TICK_CYC - 1));
    assign pwm_on = (pwm_cnt < PWM_ON_TICKS);

    always_ff @(posedge clk) begin
        if (rst) begin
            div_cnt <= 16'h0000;
        end else if (tick) begin
            div_cnt <= 16'h0000;
        end else begin
            div_cnt <= div_cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pwm_cnt <= 8'h00;
        end else if (tick) begin
            if (pwm_cnt >= PWM_PERIOD_TICKS - 8'h01) begin
                pwm_cnt <= 8'h00;
            end else begin
                pwm_cnt <= pwm_cnt + 8'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // Per-lamp mode logic
    // ----------------------------------------------------------------
    for (genvar i = 0; i < NPIN; i++) begin : g_pin
        localparam bit IS_A = (i == 0);
        logic [MODE_W-1:0] mode;
        logic              comb_en;
        logic              stretch;
        logic              prim;
        logic              evt;
        logic              shaped;
        logic              lit;

        assign mode    = mode_sel[i*MODE_W +: MODE_W];
        // Disable field only takes hold with the link/activity bit set
        assign comb_en = !(behav[BEH_LINKACT]
                           && behav[BEH_COMB + i]);
        // Legacy schemes always blink
        assign stretch = !legacy && behav[BEH_STR + i];

        always_comb begin
            prim = 1'b0;
            evt  = 1'b0;
            lit  = 1'b0;
            if (legacy) begin
                evt = link_up && any_act;
                if (strap_q) begin
                    prim = IS_A ? 1'b0 : link_up;
                end else begin
                    prim = IS_A ? (link100 || link10)
                                : (link1000 || link10);
                end
                lit = (strap_q && IS_A) ? shaped : (prim && !shaped);
            end else begin
                case (lsi_mode_t'(mode))
                    M_LOW_SPEED_LINK_ACTIVITY: begin
                        prim = link10 || link100;
                        evt  = prim && any_act;
                        lit  = prim && !(comb_en && shaped);
                    end
                    M_DUPLEX_COLLISION: begin
                        prim = link_up && full_duplex;
                        evt  = link_up && !full_duplex
                               && collision;
                        lit  = prim || (comb_en && shaped);
                    end
                    M_COLLISION: begin
                        evt = collision;
                        lit = shaped;
                    end
                    M_ACTIVITY: begin
                        evt = behav[BEH_TXACT] ? tx_activity : any_act;
                        lit = shaped;
                    end
                    M_NEG_FAULT: begin
                        lit = neg_fault;
                    end
                    M_FORCE_OFF: begin
                        lit = 1'b0;
                    end
                    M_FORCE_ON: begin
                        lit = 1'b1;
                    end
                    default: begin
                        lit = 1'b0;
                    end
                endcase
            end
            if (power_down) begin
                lit = 1'b0;
            end
        end

        lsi_shaper lsi_shaper_i (
            .clk        (clk),
            .rst        (rst),
            .tick       (tick),
            .event_in   (evt),
            .stretch_en (stretch),
            .rate       (behav[BEH_RATE + RATE_W*i +: RATE_W]),
            .shaped     (shaped)
        );

        always_ff @(posedge clk) begin
            if (rst) begin
                lamp_n[i] <= LAMP_DARK;
            end else begin
                lamp_n[i] <= !(lit && (!behav[BEH_PULSE]
                                       || pwm_on));
            end
        end
    end

    assign status_lamp_a_n = lamp_n[0];
    assign status_lamp_b_n = lamp_n[1];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic [MODE_W-1:0] mode_a;
    logic [MODE_W-1:0] mode_b;
    logic              enh_a;
    assign mode_a = mode_sel[MODE_W-1:0];
    assign mode_b = mode_sel[MODE_W +: MODE_W];
    assign enh_a  = !legacy && !power_down && !behav[BEH_PULSE];

    a_pd_dark: assert property (
        power_down |=> status_lamp_a_n && status_lamp_b_n)
        else $error("lamp lit during power-down");
    a_force_on_lit: assert property (
        enh_a && mode_a == M_FORCE_ON |=> !status_lamp_a_n)
        else $error("forced-on lamp dark");
    a_force_off_dark: assert property (
        !legacy && mode_a == M_FORCE_OFF |=> status_lamp_a_n)
        else $error("forced-off lamp lit");
    a_reserved_dark: assert property (
        !legacy && mode_a == 4'h7 |=> status_lamp_a_n)
        else $error("reserved mode lit lamp");
    a_duplex_lit: assert property (
        enh_a && mode_a == M_DUPLEX_COLLISION && link_up
        && full_duplex |=> !status_lamp_a_n)
        else $error("full duplex lamp dark");
    a_neg_fault: assert property (
        enh_a && mode_a == M_NEG_FAULT
        |=> status_lamp_a_n == !$past(neg_fault))
        else $error("fault lamp mismatch");
    a_lowspd_nolink: assert property (
        !legacy && mode_a == M_LOW_SPEED_LINK_ACTIVITY
        && !(link10 || link100) |=> status_lamp_a_n)
        else $error("low speed lamp lit without link");
    a_coll_quiet: assert property (
        !legacy && mode_a == M_COLLISION && !g_pin[0].shaped
        |=> status_lamp_a_n)
        else $error("collision lamp lit without event");
    a_pwm_bound: assert property (
        pwm_cnt < PWM_PERIOD_TICKS)
        else $error("pulsing counter out of range");
    a_pwm_gate: assert property (
        !legacy && !power_down && behav[BEH_PULSE]
        && mode_a == M_FORCE_ON && !pwm_on |=> status_lamp_a_n)
        else $error("pulsed lamp lit in off slot");
    a_read_wait: assert property (
        bus_take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    // Lamp a carries the mode checks; lamp b guards its reset mode
    a_write_ready: assert property (
        bus_take && hwrite |=> hreadyout)
        else $error("write data phase stalled");
    a_comb_darkens: assert property (
        enh_a && mode_a == M_LOW_SPEED_LINK_ACTIVITY
        && (link10 || link100) && g_pin[0].comb_en
        && g_pin[0].shaped |=> status_lamp_a_n)
        else $error("combined activity left lamp lit");
    a_comb_off_lit: assert property (
        enh_a && mode_a == M_LOW_SPEED_LINK_ACTIVITY
        && (link10 || link100) && !g_pin[0].comb_en
        |=> !status_lamp_a_n)
        else $error("uncombined link lamp dark");
    a_act_lit: assert property (
        enh_a && mode_a == M_ACTIVITY && g_pin[0].shaped
        |=> !status_lamp_a_n)
        else $error("activity flash not shown");
    a_act_quiet: assert property (
        !legacy && mode_a == M_ACTIVITY && !g_pin[0].shaped
        |=> status_lamp_a_n)
        else $error("activity lamp lit without flash");
    a_b_lowspd_dark: assert property (
        !legacy && mode_b == M_LOW_SPEED_LINK_ACTIVITY
        && !(link10 || link100) |=> status_lamp_b_n)
        else $error("lamp b lit without low speed link");
    a_legacy_link: assert property (
        legacy && !power_down && !strap_q && !behav[BEH_PULSE]
        && (link10 || link100) && !g_pin[0].shaped
        |=> !status_lamp_a_n)
        else $error("legacy lamp a dark on link");
endmodule : lsi_led_status
`default_nettype wire

// ### testbench/tb_led_status_indicator.sv
// Self-checking bench for the enhanced-mode status lamp driver
`timescale 1ns/1ps
`default_nettype none
module tb_led_status_indicator
    import lsi_pkg::*;
();
    // ------------------------------------------------------------
    // Signals and device
    // ------------------------------------------------------------
    logic        clk         = 1'b0;
    logic        rst         = 1'b1;
    logic        hsel        = 1'b0;
    logic        hwrite      = 1'b0;
    logic [31:0] haddr       = 32'h0;
    logic [31:0] hwdata      = 32'h0;
    logic [1:0]  htrans      = 2'h0;
    logic [2:0]  hsize       = 3'h2;
    logic        link_up     = 1'b0;
    logic [1:0]  link_speed  = 2'h0;
    logic        full_duplex = 1'b0;
    logic        collision   = 1'b0;
    logic        rx_activity = 1'b0;
    logic        tx_activity = 1'b0;
    logic        neg_fault   = 1'b0;
    logic        lamp_mode_strap = 1'b1;
    logic [31:0] rd_data;
    wire  logic  hreadyout;
    wire  logic  lamp_a_n;
    wire  logic  lamp_b_n;
    wire  logic  [31:0] hrdata;
    int          bad_count   = 0;
    int          checks      = 0;

    always #4 clk = ~clk;

    // Short tick keeps the 50 to 400 ms blink periods affordable
    lsi_led_status #(.TICK_CYC(2)) lsi_led_status_i (
        .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
        .link_up(link_up), .link_speed(link_speed),
        .full_duplex(full_duplex), .collision(collision),
        .rx_activity(rx_activity), .tx_activity(tx_activity),
        .neg_fault(neg_fault), .lamp_mode_strap(lamp_mode_strap),
        .status_lamp_a_n(lamp_a_n), .status_lamp_b_n(lamp_b_n)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic test_done();
        if (bad_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic bus_wait();
        int n;
        n = 0;
        @(posedge clk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 20) begin
                bad_count++;
                $display("[ERR] %0t bus wait ran out", $time);
                test_done();
            end
            @(posedge clk);
        end
    endtask : bus_wait

    // One single word transfer; read data lands in rd_data
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        bus_wait();
        htrans <= 2'h0;
        hwdata <= w ? d : 32'h0;
        bus_wait();
        rd_data = hrdata;
    endtask : bus

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd_data, e);
    endtask : rd_chk

    // Lamp b stays on mode 6 throughout
    task automatic mode_chk(input logic [3:0] m, input logic e);
        bus(1'b1, ADDR_MODE, {24'h0, 4'h6, m});
        repeat (3) @(posedge clk);
        chk({31'h0, lamp_a_n}, {31'h0, e});
    endtask : mode_chk

    task automatic lit_count(input int n, output int c);
        c = 0;
        repeat (n) begin
            @(posedge clk);
            if (lamp_a_n === 1'b0) c++;
        end
    endtask : lit_count

    task automatic flash();
        collision <= 1'b1;
        @(posedge clk);
        collision <= 1'b0;
    endtask : flash

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin : main
        int c;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({30'h0, lamp_b_n, lamp_a_n}, 32'h3);
        rd_chk(ADDR_CTRL, 32'h0);
        rd_chk(ADDR_MODE, 32'h6A);
        rd_chk(ADDR_BEHAV, 32'h0);
        bus(1'b1, 8'h10, 32'hFFFF);
        rd_chk(8'h10, 32'h0);
        link_up     <= 1'b1;
        link_speed  <= SPD_100;
        full_duplex <= 1'b1;
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(rd_data & 32'hFF, 32'h0B);
        chk({31'h0, lamp_b_n}, 32'h0);
        mode_chk(4'h8, 1'b0);
        mode_chk(4'h6, 1'b0);
        mode_chk(4'hF, 1'b0);
        mode_chk(4'hE, 1'b1);
        mode_chk(4'h7, 1'b1);
        mode_chk(4'hB, 1'b1);
        mode_chk(4'hD, 1'b1);
        mode_chk(4'hC, 1'b1);
        mode_chk(4'h9, 1'b1);
        mode_chk(4'hA, 1'b1);
        link_speed <= SPD_1000;
        mode_chk(4'h6, 1'b1);
        full_duplex <= 1'b0;
        mode_chk(4'h8, 1'b1);
        neg_fault <= 1'b1;
        mode_chk(4'hC, 1'b0);
        mode_chk(4'hF, 1'b0);
        bus(1'b1, ADDR_CTRL, 32'h2);
        repeat (3) @(posedge clk);
        chk({31'h0, lamp_a_n}, 32'h1);
        bus(1'b1, ADDR_CTRL, 32'h1);
        repeat (3) @(posedge clk);
        chk({31'h0, lamp_a_n}, 32'h1);
        bus(1'b1, ADDR_CTRL, 32'h0);
        bus(1'b1, ADDR_BEHAV, 32'h100);
        // Skip the sample launched before pulsing landed
        @(posedge clk);
        lit_count(400, c);
        chk(c, 32'h50);
        link_speed  <= SPD_100;
        rx_activity <= 1'b1;
        bus(1'b1, ADDR_BEHAV, 32'h8001);
        mode_chk(4'h6, 1'b0);
        lit_count(2000, c);
        chk(c, 32'h7D0);
        bus(1'b1, ADDR_BEHAV, 32'h0);
        lit_count(11000, c);
        chk({31'h0, c < 8000}, 32'h1);
        bus(1'b1, ADDR_MODE, 32'h6A);
        repeat (10) @(posedge clk);
        // Any window of one whole period holds exactly half lit
        lit_count(10000, c);
        chk(c, 32'h1388);
        bus(1'b1, ADDR_BEHAV, 32'h200);
        // A flash queued before the switch may still run two halves
        repeat (15010) @(posedge clk);
        lit_count(6000, c);
        chk(c, 32'h0);
        tx_activity <= 1'b1;
        lit_count(11000, c);
        chk({31'h0, c > 1000}, 32'h1);
        rx_activity <= 1'b0;
        tx_activity <= 1'b0;
        // Mid-run reset drops queued flashes; strap now picks tri-color
        rst             <= 1'b1;
        lamp_mode_strap <= 1'b0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({30'h0, lamp_b_n, lamp_a_n}, 32'h3);
        rd_chk(ADDR_MODE, 32'h6A);
        bus(1'b1, ADDR_CTRL, 32'h1);
        repeat (3) @(posedge clk);
        chk({30'h0, lamp_b_n, lamp_a_n}, 32'h2);
        bus(1'b1, ADDR_CTRL, 32'h0);
        bus(1'b1, ADDR_BEHAV, 32'h4);
        bus(1'b1, ADDR_MODE, 32'h69);
        repeat (10) @(posedge clk);
        flash();
        repeat (4) @(posedge clk);
        chk({31'h0, lamp_a_n}, 32'h0);
        repeat (9900) @(posedge clk);
        chk({31'h0, lamp_a_n}, 32'h0);
        repeat (200) @(posedge clk);
        chk({31'h0, lamp_a_n}, 32'h1);
        bus(1'b1, ADDR_BEHAV, 32'h14);
        repeat (6000) @(posedge clk);
        flash();
        repeat (15000) @(posedge clk);
        chk({31'h0, lamp_a_n}, 32'h0);
        test_done();
    end
endmodule : tb_led_status_indicator
`default_nettype wire
